// >>> rtl/cbbd_pkg.sv
`default_nettype none
package cbbd_pkg;
    // Register indices on the plain register port.
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_BIT_TIMING = 8'h01;
    localparam logic [7:0] REG_MEASURED = 8'h02;
    localparam logic [7:0] REG_SYSTEM_CONFIG = 8'h03;
    localparam logic [7:0] REG_PERIPH_SELECT = 8'h04;
    localparam int BYTE_WINDOW_BIT = 7;
    // Reset values and fields.
    localparam logic [15:0] SYSCFG_RESET = 16'h0404;
    localparam int SYSCFG_SPACE_EN_BIT = 2;
    localparam logic [15:0] PERIPH_SELECT_RESET = 16'h042D;
    localparam logic [15:0] PERIPH_SELECT_BOOT = 16'h042D;
    localparam int PSEL_XRAM_BIT = 2;
    localparam int PSEL_XPERIPH_BIT = 0;
    // Measurement and timing derivation constants.
    localparam int COUNT_W = 16;
    localparam int STUFF_BITS_TO_STOP = 5;
    localparam logic [15:0] PRESCALER_RANGE = 16'd1451;
    localparam logic [15:0] BITS_SCALE = 16'd58;
    localparam logic [7:0] TQ_MIN = 8'd8;
    localparam logic [7:0] TQ_MAX = 8'd25;
    localparam logic [1:0] SJW_FIELD = 2'b01;
    localparam logic [4:0] TIME_SEGMENT_BEFORE_SAMPLE_MAX_TQ = 5'd16;
    // Message object constants.
    localparam logic [10:0] ACK_ID = 11'h0E6;
    localparam logic [3:0] ACK_DLC = 4'h3;
    localparam logic [10:0] RX_ID = 11'h005;
    localparam logic [10:0] RX_MASK = 11'h7FF;
    localparam int BOOT_BYTES = 128;
    localparam int BYTE_IDX_W = 7;
    // Strap encodings.
    localparam logic [1:0] STRAP_ALT = 2'b01;
    localparam logic [1:0] STRAP_STD = 2'b10;
    localparam logic [1:0] STRAP_NORMAL = 2'b11;
    // Boot modes decoded from the straps.
    typedef enum logic [3:0] {
        MODE_NORMAL = 4'b0001,
        MODE_STD_BOOT = 4'b0010,
        MODE_ALT_BOOT = 4'b0100,
        MODE_TEST = 4'b1000
    } cbbd_mode_t;
    // Memory regions seen by the access check.
    typedef enum logic [1:0] {
        REGION_FETCHLESS_FLASH = 2'h0,
        REGION_EXT_FLASH = 2'h1,
        REGION_EXT_RAM = 2'h2,
        REGION_EXT_PERIPH = 2'h3
    } cbbd_region_t;
    // Acknowledge transmit object contents.
    typedef struct packed {
        logic [10:0] id;
        logic [3:0] dlc;
        logic [7:0] data0;
        logic [7:0] data1;
        logic [7:0] data2;
    } cbbd_ack_obj_t;
    // Receive object filter.
    typedef struct packed {
        logic [10:0] id;
        logic [10:0] mask;
    } cbbd_rx_obj_t;
    // Message handed over by the CAN controller.
    typedef struct packed {
        logic valid;
        logic remote;
        logic [10:0] id;
        logic [7:0] data0;
    } cbbd_msg_t;
endpackage
`default_nettype wire

// >>> rtl/cbbd_sync.sv
`default_nettype none
// Three-stage pin synchroniser; the level moves once stages two and three agree.
module cbbd_sync (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_pin,
    output logic o_level
);
    logic s1; // First stage, read by s2 only.
    logic s2; // Second stage.
    logic s3; // Third stage.

    // Shift chain; reset to recessive so no false start is seen.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Agreement filter swallows a single-cycle glitch.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_level <= 1'b1;
        end else if (s2 == s3) begin
            o_level <= s3;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/cbbd_div.sv
`default_nettype none
// Restoring divider, one quotient bit per cycle, W cycles per division.
module cbbd_div #(
    parameter int W = 16
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_start,
    input wire logic [W-1:0] i_dividend,
    input wire logic [W-1:0] i_divisor,
    output logic o_done,
    output logic [W-1:0] o_quotient,
    output logic [W-1:0] o_remainder
);
    logic [W-1:0] shreg; // Dividend bits still to be consumed.
    logic [W-1:0] divisor; // Held divisor.
    logic [$clog2(W+1)-1:0] steps; // Remaining steps.
    logic busy; // Division in progress.
    logic [W:0] trial; // Partial remainder with next bit.

    assign trial = {o_remainder, shreg[W-1]};

    // A start during a running division restarts it; the caller never does so.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            shreg <= '0;
            divisor <= '0;
            steps <= '0;
            busy <= 1'b0;
            o_done <= 1'b0;
            o_quotient <= '0;
            o_remainder <= '0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                shreg <= i_dividend;
                divisor <= i_divisor;
                steps <= ($clog2(W+1))'(W);
                busy <= 1'b1;
                o_quotient <= '0;
                o_remainder <= '0;
            end else if (busy) begin
                shreg <= {shreg[W-2:0], 1'b0};
                if (trial >= {1'b0, divisor}) begin
                    o_remainder <= W'(trial - {1'b0, divisor});
                    o_quotient <= {o_quotient[W-2:0], 1'b1};
                end else begin
                    o_remainder <= trial[W-1:0];
                    o_quotient <= {o_quotient[W-2:0], 1'b0};
                end
                steps <= steps - 1'b1;
                if (steps == 1) begin
                    busy <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/cbbd_top.sv
`default_nettype none
// Boot-time CAN bit rate detection, boot object setup and boot memory gating.
module cbbd_top #(
    parameter logic [15:0] CHIP_ID = 16'h1A2B, // Arbitrary identification value.
    parameter logic [7:0] ACK_CODE = 8'hA5 // Arbitrary acknowledge code.
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [1:0] i_boot_mode_strap_pins,
    input wire logic i_boot_can_receive_pin,
    output logic o_boot_can_transmit_pin,
    output logic o_boot_can_transmit_oe,
    input wire logic i_receive_port_user_oe,
    input wire logic i_receive_port_user_out,
    output logic o_receive_port_oe,
    output logic o_receive_port_out,
    input wire cbbd_pkg::cbbd_msg_t i_msg,
    output logic o_ack_send,
    output cbbd_pkg::cbbd_ack_obj_t o_ack_obj,
    output cbbd_pkg::cbbd_rx_obj_t o_rx_obj,
    output logic o_load_done,
    output logic o_rate_fail,
    output logic o_test_flash_at_zero,
    input wire logic i_end_of_init_instruction,
    input wire logic i_acc_valid,
    input wire cbbd_pkg::cbbd_region_t i_acc_region,
    input wire logic i_acc_fetch,
    output logic o_acc_grant,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata
);
    import cbbd_pkg::*;

    // Measurement and loading sequence, one-hot.
    typedef enum logic [6:0] {
        ST_WAIT = 7'b0000001,
        ST_COUNT = 7'b0000010,
        ST_DIV_BRP = 7'b0000100,
        ST_DIV_TQ = 7'b0001000,
        ST_LOAD = 7'b0010000,
        ST_DONE = 7'b0100000,
        ST_FAIL = 7'b1000000
    } cbbd_state_t;

    cbbd_state_t state; // Sequence state.
    cbbd_mode_t mode; // Boot mode caught from the straps.
    logic strap_taken; // Straps have been caught after release.
    logic rx_level; // Filtered receive pin level.
    logic rx_level_q; // Previous filtered level, for edges.
    logic [COUNT_W-1:0] count; // Measurement counter.
    logic [2:0] recessive_seen; // Rising edges to recessive counted so far.
    logic div_start; // Starts a division.
    logic [COUNT_W-1:0] div_divisor; // Divisor for the running division.
    logic div_done; // Division finished.
    logic [COUNT_W-1:0] div_quot; // Quotient.
    logic [COUNT_W-1:0] div_rem; // Remainder.
    logic [5:0] bit_rate_prescaler; // Derived prescaler field.
    logic [15:0] bit_timing; // Bit timing setting.
    logic [15:0] system_config; // System configuration register.
    logic [15:0] periph_select; // Peripheral selection register.
    logic init_locked; // Set once initialisation has ended.
    logic [7:0] rx_mem [BOOT_BYTES]; // Loaded boot bytes.
    logic [BYTE_IDX_W:0] byte_count; // Bytes received so far.
    logic [7:0] next_tq; // Rounded quanta per bit.
    logic rx_accept; // A boot byte message arrived.

    cbbd_sync u_sync (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_pin(i_boot_can_receive_pin),
        .o_level(rx_level)
    );

    cbbd_div #(.W(COUNT_W)) u_div (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_start(div_start),
        .i_dividend(count),
        .i_divisor(div_divisor),
        .o_done(div_done),
        .o_quotient(div_quot),
        .o_remainder(div_rem)
    );

    // Splits quanta into the two segment fields; the sample point sits near 75 %.
    // Above 23 quanta the first segment field saturates, so the point drops
    // to about 71 % at 24 quanta and 68 % at 25; that is the price of the 4-bit field.
    function automatic logic [6:0] seg_table(input logic [4:0] tq);
        logic [4:0] t2;
        logic [4:0] t1;
        t2 = 5'((tq + 5'd2) >> 2);
        t1 = 5'(tq - 5'd1 - t2);
        if (t1 > TIME_SEGMENT_BEFORE_SAMPLE_MAX_TQ) begin
            t1 = TIME_SEGMENT_BEFORE_SAMPLE_MAX_TQ;
            t2 = 5'(tq - 5'd1 - TIME_SEGMENT_BEFORE_SAMPLE_MAX_TQ);
        end
        seg_table = {3'(t2 - 5'd1), 4'(t1 - 5'd1)};
    endfunction

    // Region check used by the access port.
    function automatic logic region_allows(input cbbd_region_t r, input logic fetch,
                                           input logic boot, input logic [15:0] sel,
                                           input logic space_en);
        unique case (r)
            REGION_FETCHLESS_FLASH: region_allows = !(boot && fetch);
            REGION_EXT_FLASH: region_allows = 1'b1;
            REGION_EXT_RAM: region_allows = space_en && sel[PSEL_XRAM_BIT];
            REGION_EXT_PERIPH: region_allows = space_en && sel[PSEL_XPERIPH_BIT];
        endcase
    endfunction

    // Rounded quanta: add one when the remainder is over half the divisor.
    always_comb begin
        next_tq = div_quot[7:0];
        if ({div_rem, 1'b0} > {1'b0, div_divisor}) begin
            next_tq = 8'(div_quot + 16'd1);
        end
    end

    assign rx_accept = (state == ST_LOAD) && i_msg.valid && !i_msg.remote &&
                       ((i_msg.id & RX_MASK) == (RX_ID & RX_MASK));
    // The sequence raises a one-cycle start; the divider never sees a held level.
    logic start_pulse; // One-cycle start for the divider.
    assign div_start = start_pulse;

    // Divisor follows the stage: the fixed range first, then the prescaler scale.
    assign div_divisor = (state == ST_DIV_TQ) ?
                         16'(BITS_SCALE * ({10'h000, bit_rate_prescaler} + 16'd1)) : PRESCALER_RANGE;

    // Straps are caught in the first clocked cycle after reset release.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            strap_taken <= 1'b0;
            mode <= MODE_NORMAL;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            unique case (i_boot_mode_strap_pins)
                STRAP_ALT: mode <= MODE_ALT_BOOT;
                STRAP_STD: mode <= MODE_STD_BOOT;
                STRAP_NORMAL: mode <= MODE_NORMAL;
                default: mode <= MODE_TEST;
            endcase
        end
    end

    // Edge memory of the filtered receive level.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_level_q <= 1'b1;
        end else begin
            rx_level_q <= rx_level;
        end
    end

    // Measurement, derivation and loading sequence. Start and stop both see the
    // same synchroniser delay, so the skew cancels and stays within one cycle.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ST_WAIT;
            count <= '0;
            recessive_seen <= '0;
            start_pulse <= 1'b0;
            bit_rate_prescaler <= '0;
            bit_timing <= '0;
        end else begin
            start_pulse <= 1'b0;
            unique case (state)
                ST_WAIT: begin
                    // Only the standard loader listens for a zero frame.
                    if (strap_taken && mode == MODE_STD_BOOT && !rx_level) begin
                        state <= ST_COUNT;
                        count <= 16'h0001;
                        recessive_seen <= '0;
                    end
                end
                ST_COUNT: begin
                    if (count == {COUNT_W{1'b1}}) begin
                        state <= ST_FAIL;
                    end else if (rx_level && !rx_level_q &&
                                 recessive_seen == 3'(STUFF_BITS_TO_STOP - 1)) begin
                        state <= ST_DIV_BRP;
                        start_pulse <= 1'b1;
                    end else begin
                        count <= count + 16'h0001;
                        if (rx_level && !rx_level_q) begin
                            recessive_seen <= recessive_seen + 3'h1;
                        end
                    end
                end
                ST_DIV_BRP: begin
                    if (div_done) begin
                        bit_rate_prescaler <= div_quot[5:0];
                        state <= ST_DIV_TQ;
                        start_pulse <= 1'b1;
                    end
                end
                ST_DIV_TQ: begin
                    if (div_done) begin
                        if (next_tq < TQ_MIN || next_tq > TQ_MAX) begin
                            state <= ST_FAIL;
                        end else begin
                            // Count = 58 x (prescaler + 1) x quanta, written at once.
                            bit_timing <= {1'b0, seg_table(next_tq[4:0]), SJW_FIELD, bit_rate_prescaler};
                            state <= ST_LOAD;
                        end
                    end
                end
                ST_LOAD: begin
                    if (byte_count == (BYTE_IDX_W+1)'(BOOT_BYTES)) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: state <= ST_DONE;
                ST_FAIL: state <= ST_FAIL;
            endcase
        end
    end

    // Boot byte collection into the flop store, one data byte per message.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            byte_count <= '0;
        end else if (rx_accept && byte_count < (BYTE_IDX_W+1)'(BOOT_BYTES)) begin
            byte_count <= byte_count + 1'b1;
        end
    end

    // Store has no reset; bytes are only read after they have been written.
    always_ff @(posedge i_mclk) begin
        if (rx_accept && byte_count < (BYTE_IDX_W+1)'(BOOT_BYTES)) begin
            rx_mem[byte_count[BYTE_IDX_W-1:0]] <= i_msg.data0;
        end
    end

    // Pin drive and object outputs; the acknowledge goes out only on request.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_boot_can_transmit_pin <= 1'b1;
            o_boot_can_transmit_oe <= 1'b0;
            o_ack_send <= 1'b0;
            o_ack_obj <= '0;
            o_rx_obj <= '0;
            o_load_done <= 1'b0;
            o_rate_fail <= 1'b0;
        end else begin
            o_boot_can_transmit_pin <= 1'b1;
            o_boot_can_transmit_oe <= (state == ST_LOAD) || (state == ST_DONE);
            o_ack_send <= ((state == ST_LOAD) || (state == ST_DONE)) && i_msg.valid &&
                          i_msg.remote && (i_msg.id == ACK_ID);
            if (state == ST_DIV_TQ && div_done) begin
                o_ack_obj <= '{id: ACK_ID, dlc: ACK_DLC, data0: ACK_CODE,
                               data1: CHIP_ID[7:0], data2: CHIP_ID[15:8]};
                o_rx_obj <= '{id: RX_ID, mask: RX_MASK};
            end
            o_load_done <= (state == ST_DONE);
            o_rate_fail <= (state == ST_FAIL);
        end
    end

    // Receive pin output is blocked while the loader owns it.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_receive_port_oe <= 1'b0;
            o_receive_port_out <= 1'b1;
        end else begin
            o_receive_port_oe <= i_receive_port_user_oe && mode != MODE_STD_BOOT;
            o_receive_port_out <= i_receive_port_user_out;
        end
    end

    // Memory map state and registered access grant.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_test_flash_at_zero <= 1'b0;
            o_acc_grant <= 1'b0;
        end else begin
            o_test_flash_at_zero <= strap_taken &&
                (mode == MODE_STD_BOOT || mode == MODE_ALT_BOOT);
            o_acc_grant <= i_acc_valid && region_allows(i_acc_region, i_acc_fetch,
                mode != MODE_NORMAL, periph_select, system_config[SYSCFG_SPACE_EN_BIT]);
        end
    end

    // Configuration registers; selection may change only with the space
    // disabled and before initialisation ends. A write in the cycle the lock sets still wins.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            system_config <= SYSCFG_RESET;
            periph_select <= PERIPH_SELECT_RESET;
            init_locked <= 1'b0;
        end else begin
            if (i_end_of_init_instruction) begin
                init_locked <= 1'b1;
            end
            if (i_wr && i_addr == REG_SYSTEM_CONFIG) begin
                system_config <= i_wdata;
            end
            if (i_wr && i_addr == REG_PERIPH_SELECT && !init_locked &&
                !system_config[SYSCFG_SPACE_EN_BIT]) begin
                periph_select <= i_wdata;
            end
        end
    end

    // Read data one cycle after the read strobe; unmapped reads give zero.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            if (i_addr[BYTE_WINDOW_BIT]) begin
                o_rdata <= (i_addr[BYTE_IDX_W-1:0] < byte_count) ?
                           {8'h00, rx_mem[i_addr[BYTE_IDX_W-1:0]]} : 16'h0000;
            end else begin
                unique case (i_addr)
                    REG_STATUS: o_rdata <= {state, 1'b0, byte_count};
                    REG_BIT_TIMING: o_rdata <= bit_timing;
                    REG_MEASURED: o_rdata <= count;
                    REG_SYSTEM_CONFIG: o_rdata <= system_config;
                    REG_PERIPH_SELECT: o_rdata <= periph_select;
                    default: o_rdata <= 16'h0000;
                endcase
            end
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// >>> tb/cbbd_monitor.sv
`default_nettype none
// Watches the boot block ports; helper logic tracks the strap and accepted bytes.
module cbbd_monitor import cbbd_pkg::*; #(
    parameter logic [15:0] CHIP_ID = 16'h1A2B,
    parameter logic [7:0] ACK_CODE = 8'hA5
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [1:0] i_boot_mode_strap_pins,
    input wire logic o_boot_can_transmit_pin,
    input wire logic o_boot_can_transmit_oe,
    input wire logic o_receive_port_oe,
    input wire cbbd_pkg::cbbd_msg_t i_msg,
    input wire logic o_ack_send,
    input wire cbbd_pkg::cbbd_ack_obj_t o_ack_obj,
    input wire cbbd_pkg::cbbd_rx_obj_t o_rx_obj,
    input wire logic o_load_done,
    input wire logic o_test_flash_at_zero,
    input wire logic i_acc_valid,
    input wire cbbd_pkg::cbbd_region_t i_acc_region,
    input wire logic i_acc_fetch,
    input wire logic o_acc_grant
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt; // Cycles since reset release, saturating at three.
    logic [1:0] capt; // Strap level caught on the first edge.
    logic [7:0] nb; // Boot bytes the block should have taken.
    wire logic req = i_msg.valid && i_msg.remote && i_msg.id == ACK_ID;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    // Counting here lets the done check see early or late completion.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt <= 2'h0;
            capt <= 2'h0;
            nb <= 8'h00;
        end else begin
            if (cnt != 2'h3) cnt <= cnt + 2'h1;
            if (cnt == 2'h0) capt <= i_boot_mode_strap_pins;
            if (i_msg.valid && !i_msg.remote && i_msg.id == RX_ID && o_boot_can_transmit_oe)
                nb <= nb + 8'h01;
        end
    end
    a_tx_recessive: assert property (o_boot_can_transmit_pin) else $error("tx latch");
    a_rx_object: assert property (o_boot_can_transmit_oe |-> o_rx_obj == {RX_ID, RX_MASK})
        else $error("rx object");
    a_ack_object: assert property (o_boot_can_transmit_oe |-> o_ack_obj ==
        {ACK_ID, ACK_DLC, ACK_CODE, CHIP_ID[7:0], CHIP_ID[15:8]}) else $error("ack obj");
    a_ack_on_remote: assert property (o_boot_can_transmit_oe && req |=> o_ack_send)
        else $error("no ack");
    a_ack_only_req: assert property (o_ack_send |-> $past(req)) else $error("stray ack");
    a_rx_port_held: assert property (cnt == 2'h3 && capt == STRAP_STD |-> !o_receive_port_oe)
        else $error("rx port out");
    a_boot_map: assert property (cnt == 2'h3 |-> o_test_flash_at_zero ==
        (capt == STRAP_ALT || capt == STRAP_STD)) else $error("map");
    a_no_fetch: assert property (i_acc_valid && i_acc_fetch && o_test_flash_at_zero &&
        i_acc_region == REGION_FETCHLESS_FLASH |=> !o_acc_grant) else $error("fetch");
    a_ext_flash: assert property (i_acc_valid && i_acc_region == REGION_EXT_FLASH |=> o_acc_grant)
        else $error("extension_flash_region");
    a_load_count: assert property ($rose(o_load_done) |-> nb == 8'd128)
        else $error("done count");
endmodule
bind cbbd_top cbbd_monitor #(.CHIP_ID(CHIP_ID), .ACK_CODE(ACK_CODE)) mon_u (.*);
`default_nettype wire

// >>> tb/cbbd_host.sv
`default_nettype none
// CAN host: zero frame on the receive line and messages handed over by the controller.
module cbbd_host import cbbd_pkg::*; (
    input wire logic i_mclk,
    output logic o_rx,
    output cbbd_pkg::cbbd_msg_t o_msg
);
    timeunit 1ns;
    timeprecision 1ns;
    // Zero identifier, zero length frame; dominant is 0, tail stays recessive.
    localparam logic [46:0] ZF = 47'b000001_000001_000001_000001_000001_0000_1_0_11111111111;
    initial o_rx = 1'b1;
    initial o_msg = '0;
    task automatic zero_frame(input int bt);
        for (int i = 46; i >= 0; i--) begin
            o_rx <= ZF[i];
            repeat (bt) @(posedge i_mclk);
        end
    endtask
    // Valid stays up between back-to-back sends; quiet drops it once.
    task automatic send(input logic rem, input logic [10:0] id, input logic [7:0] d);
        o_msg <= '{1'b1, rem, id, d};
        @(posedge i_mclk);
    endtask
    task automatic quiet;
        o_msg <= '0;
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, a, e); end end
module tb_top;
    import cbbd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk, i_nrst, i_wr, i_rd, i_acc_valid, i_acc_fetch, i_end_of_init_instruction;
    logic i_boot_can_receive_pin, i_receive_port_user_oe, i_receive_port_user_out;
    logic o_boot_can_transmit_pin, o_boot_can_transmit_oe, o_receive_port_oe, o_receive_port_out;
    logic o_ack_send, o_load_done, o_rate_fail, o_test_flash_at_zero, o_acc_grant, rd_q, av_q, xg;
    logic [1:0] i_boot_mode_strap_pins;
    logic [7:0] i_addr;
    logic [15:0] i_wdata, o_rdata, xr;
    logic [7:0] b [128]; // Boot bytes as sent.
    cbbd_msg_t i_msg;
    cbbd_ack_obj_t o_ack_obj;
    cbbd_rx_obj_t o_rx_obj;
    cbbd_region_t i_acc_region;
    logic [15:0] rq[$]; // Expected read data, oldest first.
    logic gq[$]; // Expected grants, oldest first.
    int err_count = 0, n_tests = 0, seed = 69081, k = 0;
    cbbd_top dut_u (.*);
    cbbd_host host_u (.i_mclk(i_mclk), .o_rx(i_boot_can_receive_pin), .o_msg(i_msg));
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    task automatic complete_run;
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Each task leaves a idle cycle so no strobe is assigned twice in one step.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        rq.push_back(e);
        {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic acc(input cbbd_region_t r, input logic f, input logic e);
        gq.push_back(e);
        {i_acc_region, i_acc_fetch, i_acc_valid} <= {r, f, 1'b1};
        @(posedge i_mclk);
        i_acc_valid <= 1'b0;
        @(posedge i_mclk);
    endtask
    // Results stand only in the cycle after the request, so compare there.
    always @(posedge i_mclk) begin
        if (rd_q) begin
            xr = rq.pop_front();
            `CHK(o_rdata, xr)
        end
        if (av_q) begin
            xg = gq.pop_front();
            `CHK(o_acc_grant, xg)
        end
        rd_q <= i_rd;
        av_q <= i_acc_valid;
    end
    initial begin
        {i_nrst, i_wr, i_rd, i_acc_valid, i_acc_fetch, i_end_of_init_instruction} = '0;
        {i_addr, i_wdata, rd_q, av_q, i_receive_port_user_out} = '0;
        {i_acc_region, i_boot_mode_strap_pins, i_receive_port_user_oe} = '1;
        for (int s = 3; s >= 1; s--) begin
            i_nrst <= 1'b0;
            i_boot_mode_strap_pins <= 2'(s == 3 ? 3 : 3 - s);
            i_receive_port_user_out <= 1'($random(seed));
            repeat (2) @(posedge i_mclk);
            i_nrst <= 1'b1;
            repeat (3) @(posedge i_mclk);
            acc(REGION_FETCHLESS_FLASH, 1'b1, s == 3);
        end
        rd(REG_SYSTEM_CONFIG, SYSCFG_RESET);
        rd(REG_PERIPH_SELECT, PERIPH_SELECT_RESET);
        rd(8'h10, 16'h0000);
        acc(REGION_EXT_RAM, 1'b0, 1'b1);
        wr(REG_PERIPH_SELECT, 16'h0000);
        rd(REG_PERIPH_SELECT, 16'h042D);
        wr(REG_SYSTEM_CONFIG, 16'h0400);
        wr(REG_PERIPH_SELECT, 16'h0001);
        rd(REG_PERIPH_SELECT, 16'h0001);
        acc(REGION_EXT_PERIPH, 1'b0, 1'b0);
        wr(REG_SYSTEM_CONFIG, 16'h0404);
        acc(REGION_EXT_RAM, 1'b0, 1'b0);
        acc(REGION_EXT_PERIPH, 1'b0, 1'b1);
        wr(REG_SYSTEM_CONFIG, 16'h0400);
        i_end_of_init_instruction <= 1'b1;
        @(posedge i_mclk);
        i_end_of_init_instruction <= 1'b0;
        wr(REG_PERIPH_SELECT, 16'h0004);
        rd(REG_PERIPH_SELECT, 16'h0001);
        // 20 cycles a bit gives 580 counts: prescaler 0, ten quanta split 7 to 3.
        host_u.zero_frame(20);
        repeat (100) @(posedge i_mclk);
        rd(REG_BIT_TIMING, 16'h2540);
        for (int i = 0; i < 130; i++) begin
            if (i == 40) host_u.send(1'b1, ACK_ID, 8'h00);
            else if (i == 90) host_u.send(1'b0, 11'h006, 8'hFF);
            else begin
                b[k] = 8'($random(seed));
                host_u.send(1'b0, RX_ID, b[k]);
                k++;
            end
        end
        host_u.quiet();
        repeat (4) @(posedge i_mclk);
        rd(REG_STATUS, 16'h4080);
        for (int i = 0; i < 128; i++) rd(8'(8'h80 + i), {8'h00, b[i]});
        repeat (3) @(posedge i_mclk);
        `CHK(o_rate_fail, 1'b0)
        `CHK(o_boot_can_transmit_oe, 1'b1)
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        err_count++;
        complete_run;
    end
endmodule
`default_nettype wire
